// File: src/adcsc_top.sv
// Scan select, compare hit, charge unit and reference enable registers with AHB-Lite access
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module adcsc_top
    import adcsc_pkg::*;
#(
    parameter bit SMALL_PKG = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_res_wr,
    input wire logic [3:0] i_res_ch,
    input wire logic i_match,
    input wire logic i_conv_done,
    input wire logic i_converting,
    output logic o_halfgap_ref_on,
    output logic o_gap_ref_on,
    output logic [4:0] o_scan_ch,
    output logic o_scan_valid,
    output logic o_charge_unit_on,
    output logic o_conv_clock_tick,
    output logic o_irq
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [15:0] MASK_CH = SMALL_PKG ? MASK_CH_SMALL : MASK_CH_BIG;
    localparam logic [15:0] MASK_CSSL = SMALL_PKG ? MASK_CSSL_SMALL : MASK_CSSL_BIG;

    adcsc_bus_t bus_st_reg;
    logic [7:0] addr_reg;
    logic take;
    logic wr_commit;
    logic [15:0] wdata;
    logic [15:0] rd_next;
    logic [15:0] bgcfg_reg;
    logic [15:0] hit_reg;
    logic [15:0] cssh_reg;
    logic [15:0] cssl_reg;
    logic [15:0] chgcon_reg;
    logic [15:0] conv_reg;
    logic [15:0] ist_reg;
    logic [15:0] ien_reg;
    logic [15:0] hit_set;
    logic [31:0] sel_all;
    logic [4:0] scan_nxt;
    logic [4:0] scan_first;
    logic scan_en;
    logic wrap_evt;
    logic [7:0] div;
    logic [7:0] clk_div_cnt_reg;
    adcsc_mode_t mode;

    assign take = i_hsel && i_htrans[1] && i_hready;
    assign wr_commit = (bus_st_reg == BS_WR);
    assign wdata = i_hwdata[15:0];
    assign mode = adcsc_mode_t'(conv_reg[CONV_MODE_LSB +: 2]);
    assign div = conv_reg[CONV_DIV_LSB +: 8];
    assign scan_en = conv_reg[CONV_SCAN_BIT];
    assign sel_all = {cssh_reg, cssl_reg};

    // ****************************************
    // Bus slave
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bus_st_reg <= BS_IDLE;
            addr_reg <= 8'h00;
        end else if (bus_st_reg == BS_RDW) begin
            bus_st_reg <= BS_RDO;
        end else if (take) begin
            bus_st_reg <= i_hwrite ? BS_WR : BS_RDW;
            addr_reg <= i_haddr[7:0];
        end else begin
            bus_st_reg <= BS_IDLE;
        end
    end

    always_comb begin
        unique case (addr_reg)
            ADR_BGCFG: rd_next = bgcfg_reg;
            ADR_HIT: rd_next = hit_reg;
            ADR_CSSH: rd_next = cssh_reg;
            ADR_CSSL: rd_next = cssl_reg;
            ADR_CHGCON: rd_next = chgcon_reg;
            ADR_CONV: rd_next = conv_reg;
            ADR_IST: rd_next = ist_reg;
            ADR_IEN: rd_next = ien_reg;
            default: rd_next = RST_REG;
        endcase
    end

    // One wait state on reads so a write just before is already visible
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h0000_0000;
        end else if (bus_st_reg == BS_RDW) begin
            o_hreadyout <= 1'b1;
            o_hrdata <= {16'h0000, rd_next};
        end else if (take && !i_hwrite) begin
            o_hreadyout <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        o_hresp <= 1'b0;
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bgcfg_reg <= RST_REG;
            cssh_reg <= RST_REG;
            cssl_reg <= RST_REG;
            chgcon_reg <= RST_REG;
            conv_reg <= RST_REG;
            ien_reg <= RST_REG;
        end else if (wr_commit) begin
            unique case (addr_reg)
                ADR_BGCFG: bgcfg_reg <= wdata & MASK_BGCFG;
                ADR_CSSH: cssh_reg <= wdata & MASK_CSSH;
                ADR_CSSL: cssl_reg <= wdata & MASK_CSSL;
                ADR_CHGCON: chgcon_reg <= wdata & MASK_CH;
                ADR_CONV: conv_reg <= wdata & MASK_CONV;
                ADR_IEN: ien_reg <= wdata & MASK_IRQ;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_halfgap_ref_on <= 1'b0;
            o_gap_ref_on <= 1'b0;
        end else begin
            o_halfgap_ref_on <= bgcfg_reg[BG_HALF_BIT];
            o_gap_ref_on <= bgcfg_reg[BG_FULL_BIT];
        end
    end

    // ****************************************
    // Compare hit flags
    // ****************************************
    for (genvar k = 0; k < 16; k++) begin : g_hit
        if (MASK_CH[k]) begin : g_on
            // Outside-window also flags any buffer write
            assign hit_set[k] = i_res_wr && (i_res_ch == 4'(k)) &&
                                (i_match || mode == CMP_OUT);
            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    hit_reg[k] <= 1'b0;
                end else if (hit_set[k]) begin
                    hit_reg[k] <= 1'b1;
                end else if (wr_commit && addr_reg == ADR_HIT) begin
                    hit_reg[k] <= wdata[k];
                end
            end
        end else begin : g_off
            assign hit_set[k] = 1'b0;
            always_ff @(posedge i_clk) begin
                hit_reg[k] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Scan sequencer
    // ****************************************
    function automatic logic [4:0] next_sel(input logic [31:0] sel, input logic [4:0] cur);
        logic [4:0] nx;
        logic [4:0] c;
        logic found;
        nx = cur;
        found = 1'b0;
        for (int n = 1; n <= 32; n++) begin
            c = cur + 5'(n);
            if (!found && sel[c]) begin
                nx = c;
                found = 1'b1;
            end
        end
        return nx;
    endfunction : next_sel

    assign scan_nxt = next_sel(sel_all, o_scan_ch);
    assign scan_first = next_sel(sel_all, 5'h1F);
    assign wrap_evt = scan_en && o_scan_valid && i_conv_done && (scan_nxt <= o_scan_ch);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_scan_ch <= 5'h00;
            o_scan_valid <= 1'b0;
        end else begin
            o_scan_valid <= |sel_all;
            if (!scan_en) begin
                o_scan_ch <= scan_first;
            end else if (i_conv_done) begin
                o_scan_ch <= scan_nxt;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_charge_unit_on <= 1'b0;
        end else begin
            o_charge_unit_on <= i_converting && o_scan_valid && !o_scan_ch[4] &&
                                chgcon_reg[o_scan_ch[3:0]];
        end
    end

    // ****************************************
    // Conversion clock divider
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            clk_div_cnt_reg <= RST_CNT;
            o_conv_clock_tick <= 1'b0;
        end else if (clk_div_cnt_reg >= div) begin
            clk_div_cnt_reg <= RST_CNT;
            o_conv_clock_tick <= 1'b1;
        end else begin
            clk_div_cnt_reg <= clk_div_cnt_reg + 8'h01;
            o_conv_clock_tick <= 1'b0;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ist_reg <= RST_REG;
        end else begin
            // Event set wins over a clear in the same cycle
            ist_reg <= ((wr_commit && addr_reg == ADR_ICLR) ? (ist_reg & ~wdata) : ist_reg) |
                       ({14'h0000, wrap_evt, |hit_set} & MASK_IRQ);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(ist_reg & ien_reg);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_bg_wr;
        wr_commit && addr_reg == ADR_BGCFG;
    endsequence

    sequence s_rd_take;
        take && !i_hwrite;
    endsequence

    property p_half_ref;
        s_bg_wr |=> ##1 (o_halfgap_ref_on == $past(i_hwdata[1], 2));
    endproperty
    a_half_ref: assert property (p_half_ref) else $error("half ref enable wrong");

    property p_full_ref;
        s_bg_wr |=> ##1 (o_gap_ref_on == $past(i_hwdata[0], 2));
    endproperty
    a_full_ref: assert property (p_full_ref) else $error("full ref enable wrong");

    property p_rd_upper_zero;
        s_rd_take |=> !o_hreadyout ##1 (o_hreadyout && o_hrdata[31:16] == 16'h0000);
    endproperty
    a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("read timing or upper bits wrong");

    property p_out_wr_hit;
        i_res_wr && i_res_ch == 4'h3 && mode == CMP_OUT |=> hit_reg[3];
    endproperty
    a_out_wr_hit: assert property (p_out_wr_hit) else $error("outside mode write did not set hit");

    property p_no_match_hold;
        !i_match && mode != CMP_OUT && !hit_reg[3] && !wr_commit |=> !hit_reg[3];
    endproperty
    a_no_match_hold: assert property (p_no_match_hold) else $error("hit set without match");

    property p_hit_gaps;
        hit_reg[8] == 1'b0 && hit_reg[15:13] == 3'b000;
    endproperty
    a_hit_gaps: assert property (p_hit_gaps) else $error("absent hit bit set");

    property p_small_pkg;
        SMALL_PKG |-> hit_reg[12:10] == 3'b000 && cssl_reg[12:10] == 3'b000 && chgcon_reg[12:10] == 3'b000;
    endproperty
    a_small_pkg: assert property (p_small_pkg) else $error("small package bits present");

    property p_scan_step;
        scan_en && i_conv_done && $stable(sel_all) |=> o_scan_ch == $past(scan_nxt) && sel_all[o_scan_ch];
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan did not step to next enabled");

    property p_charge_unit;
        o_charge_unit_on |-> $past(i_converting) && $past(chgcon_reg[o_scan_ch[3:0]]);
    endproperty
    a_charge_unit: assert property (p_charge_unit) else $error("charge unit on without connect");

    property p_conv_clk_div2;
        o_conv_clock_tick ##1 (div == 8'h02 && !o_conv_clock_tick) [*2] |=> o_conv_clock_tick;
    endproperty
    a_conv_clk_div2: assert property (p_conv_clk_div2) else $error("conversion clock period wrong");

    property p_conv_clk_div1;
        div == 8'h00 |=> o_conv_clock_tick;
    endproperty
    a_conv_clk_div1: assert property (p_conv_clk_div1) else $error("conversion clock not every cycle");

    property p_match_hit;
        i_res_wr && i_match && i_res_ch == 4'h4 |=> hit_reg[4];
    endproperty
    a_match_hit: assert property (p_match_hit) else $error("match did not set hit");

    property p_unimpl_zero;
        bgcfg_reg[15:2] == 14'h0000 && cssh_reg[10:0] == 11'h000 && !cssl_reg[15] && !cssl_reg[8] &&
        chgcon_reg[15:13] == 3'b000 && !chgcon_reg[8];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit stored");

    property p_scan_wrap;
        scan_en && i_conv_done && $stable(sel_all) && scan_nxt <= o_scan_ch |=>
            (sel_all & ((32'h0000_0001 << o_scan_ch) - 32'h0000_0001)) == 32'h0000_0000;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap to lowest channel");

    property p_charge_off;
        !i_converting |=> !o_charge_unit_on;
    endproperty
    a_charge_off: assert property (p_charge_off) else $error("charge unit on while idle");

endmodule : adcsc_top

`default_nettype wire

// File: common/adcsc_pkg.sv
// Shared constants and types for the converter scan and compare configuration block
`default_nettype none
package adcsc_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] ADR_BGCFG = 8'h00;
    localparam logic [7:0] ADR_HIT = 8'h04;
    localparam logic [7:0] ADR_CSSH = 8'h08;
    localparam logic [7:0] ADR_CSSL = 8'h0C;
    localparam logic [7:0] ADR_CHGCON = 8'h10;
    localparam logic [7:0] ADR_CONV = 8'h14;
    localparam logic [7:0] ADR_IST = 8'h18;
    localparam logic [7:0] ADR_ICLR = 8'h1C;
    localparam logic [7:0] ADR_IEN = 8'h20;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BG_FULL_BIT = 0;
    localparam int BG_HALF_BIT = 1;
    localparam int CONV_DIV_LSB = 0;
    localparam int CONV_MODE_LSB = 8;
    localparam int CONV_SCAN_BIT = 15;
    localparam int IRQ_HIT_BIT = 0;
    localparam int IRQ_WRAP_BIT = 1;

    // ****************************************
    // Implemented bit masks
    // ****************************************
    localparam logic [15:0] MASK_BGCFG = 16'h0003;
    localparam logic [15:0] MASK_CH_BIG = 16'h1EFF;
    localparam logic [15:0] MASK_CH_SMALL = 16'h02FF;
    localparam logic [15:0] MASK_CSSH = 16'hF800;
    localparam logic [15:0] MASK_CSSL_BIG = 16'h7EFF;
    localparam logic [15:0] MASK_CSSL_SMALL = 16'h62FF;
    localparam logic [15:0] MASK_CONV = 16'h83FF;
    localparam logic [15:0] MASK_IRQ = 16'h0003;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [7:0] RST_CNT = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        CMP_LT = 2'b00,
        CMP_GT = 2'b01,
        CMP_IN = 2'b10,
        CMP_OUT = 2'b11
    } adcsc_mode_t;

    typedef enum logic [3:0] {
        BS_IDLE = 4'b0001,
        BS_WR = 4'b0010,
        BS_RDW = 4'b0100,
        BS_RDO = 4'b1000
    } adcsc_bus_t;

endpackage : adcsc_pkg

`default_nettype wire

// File: tb/adcsc_top_tb.sv
// Self-checking testbench for the converter scan and compare configuration block
`timescale 1ns/100ps
`default_nettype none

module adcsc_top_tb
    import adcsc_pkg::*;
;
    // ****************************************
    // Signals and design instances
    // ****************************************
    logic clk, rst_b, hsel, hwrite, hready, res_wr, match, conv_done, converting;
    logic half_on, gap_on, scan_valid, chg_on, conv_tick, irq, hready_s, hresp;
    logic [31:0] haddr, hwdata, hrdata, hrdata_s, rdata, rdata_s, sel, seed, wval;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] res_ch;
    logic [4:0] scan_ch, ch, nx;
    logic [15:0] cssl, cssh, ctm, hexp;
    logic [7:0] div;
    logic [7:0] addr_t [10];
    logic [15:0] mask_t [10];
    logic [15:0] mask_s [10];
    int fails, checks_done, cyc, cnt;

    adcsc_top #(.SMALL_PKG(1'b0)) u_dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_res_wr(res_wr), .i_res_ch(res_ch),
        .i_match(match), .i_conv_done(conv_done), .i_converting(converting),
        .o_halfgap_ref_on(half_on), .o_gap_ref_on(gap_on), .o_scan_ch(scan_ch),
        .o_scan_valid(scan_valid), .o_charge_unit_on(chg_on), .o_conv_clock_tick(conv_tick), .o_irq(irq));

    // Small package variant shares the bus; only its read data is judged
    adcsc_top #(.SMALL_PKG(1'b1)) u_dut_small (
        .i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready_s), .o_hresp(), .o_hrdata(hrdata_s), .i_res_wr(res_wr), .i_res_ch(res_ch),
        .i_match(match), .i_conv_done(conv_done), .i_converting(converting),
        .o_halfgap_ref_on(), .o_gap_ref_on(), .o_scan_ch(), .o_scan_valid(), .o_charge_unit_on(),
        .o_conv_clock_tick(), .o_irq());

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    // ****************************************
    // Tasks and expectation helpers
    // ****************************************
    task automatic report_and_stop();
        $display("Checks: %0d  mismatches: %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Ready is registered, so it is settled at the falling edge before the sampling edge
    task automatic wait_rdy();
        @(negedge clk);
        while (hready !== 1'b1) begin
            @(negedge clk);
        end
        rdata = hrdata;
        rdata_s = hrdata_s;
        @(posedge clk);
    endtask : wait_rdy

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] es);
        bus(a, 1'b0, 32'h00000000);
        chk(rdata, {16'h0000, e}, "read data");
        chk(rdata_s, {16'h0000, es}, "small package read data");
        chk(hresp, 1'b0, "okay response");
    endtask : rd

    task automatic hit(input logic [3:0] c, input logic m);
        @(posedge clk);
        res_wr <= 1'b1;
        res_ch <= c;
        match <= m;
        @(posedge clk);
        res_wr <= 1'b0;
        match <= 1'b0;
    endtask : hit

    // Next selected channel above cur, else the lowest selected one
    function automatic logic [4:0] next_ch(input logic [31:0] s, input logic [4:0] cur);
        logic [4:0] r;
        r = cur;
        for (int i = 31; i >= 0; i--) if (s[i]) r = i[4:0];
        for (int i = 31; i > cur; i--) if (s[i]) r = i[4:0];
        return r;
    endfunction : next_ch

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
        hwdata = 32'h0; res_wr = 1'b0; res_ch = 4'h0; match = 1'b0; conv_done = 1'b0;
        converting = 1'b0; fails = 0; checks_done = 0; cyc = 0;
        seed = $urandom(32'h6CDC7CA2);
        addr_t = '{ADR_BGCFG, ADR_HIT, ADR_CSSH, ADR_CSSL, ADR_CHGCON, ADR_CONV, ADR_IST, ADR_ICLR, ADR_IEN, 8'h24};
        mask_t = '{MASK_BGCFG, MASK_CH_BIG, MASK_CSSH, MASK_CSSL_BIG, MASK_CH_BIG, MASK_CONV, 16'h0, 16'h0, MASK_IRQ, 16'h0};
        mask_s = '{MASK_BGCFG, MASK_CH_SMALL, MASK_CSSH, MASK_CSSL_SMALL, MASK_CH_SMALL, MASK_CONV, 16'h0, 16'h0, MASK_IRQ, 16'h0};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) rd(addr_t[i], 16'h0000, 16'h0000);
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 10; i++) begin
                wval = (r == 0) ? 32'hFFFFFFFF : (r == 3) ? 32'h00000000 : $urandom;
                wr(addr_t[i], wval);
                rd(addr_t[i], wval[15:0] & mask_t[i], wval[15:0] & mask_s[i]);
            end
        end
        for (int v = 0; v < 4; v++) begin
            wr(ADR_BGCFG, v);
            repeat (2) @(negedge clk);
            chk({half_on, gap_on}, v, "reference enables");
        end
        for (int m = 0; m < 4; m++) begin
            wr(ADR_CONV, m << 8);
            wr(ADR_HIT, 32'h0);
            hit(4'd3, 1'b0);
            hit(4'd4, 1'b1);
            hit(4'd11, 1'b1);
            hit(4'd8, 1'b1);
            hit(4'd13, 1'b1);
            hit(4'd15, 1'b1);
            hexp = (m == 3) ? 16'h0018 : 16'h0010;
            rd(ADR_HIT, hexp | 16'h0800, hexp);
        end
        rd(ADR_IST, 16'h0001, 16'h0001);
        chk(irq, 1'b0, "masked interrupt");
        wr(ADR_IEN, 32'h1);
        repeat (2) @(negedge clk);
        chk(irq, 1'b1, "enabled interrupt");
        wr(ADR_ICLR, 32'h1);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0, "cleared interrupt");
        rd(ADR_IST, 16'h0000, 16'h0000);
        cssl = 16'($urandom & MASK_CSSL_BIG) | 16'h0004;
        cssh = 16'($urandom & MASK_CSSH) | 16'h8000;
        ctm = 16'($urandom & MASK_CH_BIG);
        sel = {cssh[15:11], 11'h000, cssl};
        wr(ADR_CSSL, cssl);
        wr(ADR_CSSH, cssh);
        wr(ADR_CHGCON, ctm);
        wr(ADR_IEN, 32'h2);
        repeat (2) @(negedge clk);
        ch = next_ch(sel, 5'd31);
        chk(scan_ch, ch, "lowest scan channel");
        chk(scan_valid, 1'b1, "scan valid");
        @(posedge clk);
        converting <= 1'b1;
        wr(ADR_CONV, 32'h8000);
        for (int k = 0; k < 25; k++) begin
            @(posedge clk);
            conv_done <= 1'b1;
            @(posedge clk);
            conv_done <= 1'b0;
            @(negedge clk);
            nx = next_ch(sel, ch);
            ch = nx;
            chk(scan_ch, ch, "scan step");
            @(negedge clk);
            chk(chg_on, (ch < 5'd16) ? ctm[ch[3:0]] : 1'b0, "charge unit connect");
        end
        chk(irq, 1'b1, "wrap interrupt");
        @(posedge clk);
        converting <= 1'b0;
        repeat (2) @(negedge clk);
        chk(chg_on, 1'b0, "charge unit idle");
        for (int k = 0; k < 4; k++) begin
            div = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : (k == 2) ? 8'h02 : 8'($urandom % 16);
            wr(ADR_CONV, {24'h000000, div});
            repeat (3) @(negedge clk);
            cnt = 0;
            for (int c = 0; c < (div + 1) * 10; c++) begin
                @(negedge clk);
                if (conv_tick === 1'b1) cnt++;
            end
            chk(cnt, 10, "conversion clock ticks");
        end
        report_and_stop();
    end

endmodule : adcsc_top_tb

`default_nettype wire
